// ===== rtl/pxc_pkg.sv
// Constants for the extended control register two block.
// Assumes a management frame engine outside that decodes register address and data.
package pxc_pkg;
	localparam logic [4:0]  EXT_CTRL_TWO_ADDR = 5'h13;
	localparam int          BIT_REPEATER      = 15;
	localparam int          BIT_SW_MODE       = 14;
	localparam int          BIT_REMOTE_FAULT  = 13;
	localparam int          BIT_HIZ           = 7;
	localparam int          BIT_AUTO_PD       = 0;
	localparam logic [15:0] RW_MASK           = 16'h1BFF;
	localparam logic [15:0] RW_RESET          = 16'h0001;
endpackage : pxc_pkg

// ===== rtl/pxc_ext_ctrl.sv
// Extended control register two with its mode and power-down effects.
// Assumes management frames are decoded outside into one-cycle strobes on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module pxc_ext_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        mgmt_wr,
	input  wire logic        mgmt_rd,
	input  wire logic [4:0]  mgmt_reg_addr,
	input  wire logic [15:0] mgmt_wdata,
	output logic      [15:0] mgmt_rdata,
	input  wire logic        node_repeater_strap,
	input  wire logic        sw_mode_strap,
	input  wire logic        partner_remote_fault,
	input  wire logic        isolate,
	input  wire logic        link_is_10base_t,
	input  wire logic        tx_activity,
	input  wire logic        rx_activity,
	input  wire logic        pin_cfg_speed_100,
	input  wire logic        reg_cfg_speed_100,
	output logic             cfg_speed_100,
	output logic             sqe_test_enable,
	output logic             carrier_sense,
	output logic             pair_tx_positive_oe,
	output logic             pair_tx_negative_oe,
	output logic             tx100_power_down
);
	logic [15:0] rw_q;
	logic        repeater_q;
	logic        sw_mode_q;
	logic [1:0]  rep_sync_q;
	logic [1:0]  sw_sync_q;
	logic [1:0]  rf_sync_q;
	logic        strap_taken_q;
	logic        hit;

	assign hit = mgmt_reg_addr == pxc_pkg::EXT_CTRL_TWO_ADDR;

	// Straps and partner fault come from outside the clock domain
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rep_sync_q <= 2'h0;
			sw_sync_q  <= 2'h0;
			rf_sync_q  <= 2'h0;
		end else if (clk_en) begin
			rep_sync_q <= {rep_sync_q[0], node_repeater_strap};
			sw_sync_q  <= {sw_sync_q[0], sw_mode_strap};
			rf_sync_q  <= {rf_sync_q[0], partner_remote_fault};
		end
	end

	// Straps caught once after release, once the synchronisers have filled
	logic [1:0] strap_wait_q;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			strap_wait_q  <= 2'h0;
			strap_taken_q <= 1'b0;
			repeater_q    <= 1'b0;
			sw_mode_q     <= 1'b1;
		end else if (clk_en) begin
			if (strap_wait_q != 2'h2)
				strap_wait_q <= strap_wait_q + 2'h1;
			else if (!strap_taken_q) begin
				strap_taken_q <= 1'b1;
				repeater_q    <= rep_sync_q[1];
				sw_mode_q     <= sw_sync_q[1];
			end
		end
	end

	// Reserved writable bits keep what is written; bit 10 stays 0
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			rw_q <= pxc_pkg::RW_RESET;
		else if (clk_en && mgmt_wr && hit)
			rw_q <= mgmt_wdata & pxc_pkg::RW_MASK;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			mgmt_rdata <= 16'h0000;
		else if (clk_en && mgmt_rd && hit) begin
			mgmt_rdata <= rw_q;
			mgmt_rdata[pxc_pkg::BIT_REPEATER]     <= repeater_q;
			mgmt_rdata[pxc_pkg::BIT_SW_MODE]      <= sw_mode_q;
			mgmt_rdata[pxc_pkg::BIT_REMOTE_FAULT] <= rf_sync_q[1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cfg_speed_100       <= 1'b0;
			sqe_test_enable     <= 1'b0;
			carrier_sense       <= 1'b0;
			pair_tx_positive_oe <= 1'b1;
			pair_tx_negative_oe <= 1'b1;
			tx100_power_down    <= 1'b0;
		end else if (clk_en) begin
			cfg_speed_100 <= sw_mode_q ? reg_cfg_speed_100 : pin_cfg_speed_100;
			sqe_test_enable <= !repeater_q;
			// Repeater carrier follows receive only
			carrier_sense <= repeater_q ? rx_activity
				: (tx_activity || rx_activity);
			pair_tx_positive_oe <= !rw_q[pxc_pkg::BIT_HIZ];
			pair_tx_negative_oe <= !rw_q[pxc_pkg::BIT_HIZ];
			tx100_power_down <= isolate
				|| (rw_q[pxc_pkg::BIT_AUTO_PD] && link_is_10base_t);
		end
	end

	// Drivers follow the stored bit one enabled edge later
	a_hiz_follows_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && rw_q[pxc_pkg::BIT_HIZ] |=> !clk_en || (!pair_tx_positive_oe
			&& !pair_tx_negative_oe))
		else $error("transmit driver enabled while high impedance set");
	a_powerdown_auto: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && rw_q[0] && link_is_10base_t |=> !clk_en || tx100_power_down)
		else $error("no automatic power down in 10Base-T");
	a_powerdown_isolate: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && isolate |=> !clk_en || tx100_power_down)
		else $error("isolate did not power down");
	a_no_powerdown: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && !rw_q[0] && !isolate |=> !clk_en || !tx100_power_down)
		else $error("power down without cause");
	a_reserved_ro: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!rw_q[10] && !rw_q[15] && !rw_q[14] && !rw_q[13])
		else $error("read-only bit stored");
	a_node_crs: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && !repeater_q && tx_activity |=> !clk_en || carrier_sense)
		else $error("carrier missing on transmit in node mode");
	a_node_sqe: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && !repeater_q |=> !clk_en || sqe_test_enable)
		else $error("SQE test off in node mode");
	a_sw_cfg: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && sw_mode_q |=> !clk_en || cfg_speed_100 == $past(reg_cfg_speed_100))
		else $error("software mode ignored register config");
	a_fault_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && mgmt_rd && hit |=> mgmt_rdata[13] == $past(rf_sync_q[1]))
		else $error("remote fault not mirrored");
	a_write_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && mgmt_wr && hit |=> rw_q == ($past(mgmt_wdata) & pxc_pkg::RW_MASK))
		else $error("write not stored");
	a_strap_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		strap_taken_q && $past(strap_taken_q) |-> $stable(repeater_q) && $stable(sw_mode_q))
		else $error("strap value changed after capture");
endmodule : pxc_ext_ctrl
`default_nettype wire

// ===== verif/pxc_sme_model.sv
// Management entity model: writes and reads register two.
// Assumes clk_sys from the bench; tasks are called hierarchically.
`timescale 1ns/10ps
`default_nettype none
module pxc_sme_model (
	input  wire logic        clk_sys,
	output logic             mgmt_wr = 1'b0,
	output logic             mgmt_rd = 1'b0,
	output logic      [4:0]  mgmt_reg_addr = 5'h00,
	output logic      [15:0] mgmt_wdata = 16'h0000,
	input  wire logic [15:0] mgmt_rdata
);
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		mgmt_reg_addr <= a;
		mgmt_wdata    <= d & 16'h0081;
		mgmt_wr       <= 1'b1;
		@(posedge clk_sys);
		mgmt_wr    <= 1'b0;
		mgmt_wdata <= ~mgmt_wdata;
	endtask : wr
	task automatic rd(output logic [15:0] q);
		@(posedge clk_sys);
		mgmt_reg_addr <= 5'h13;
		mgmt_rd       <= 1'b1;
		@(posedge clk_sys);
		mgmt_rd <= 1'b0;
		@(negedge clk_sys);
		q = mgmt_rdata;
	endtask : rd
endmodule : pxc_sme_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the register two block.
// Assumes the management model drives the register strobes.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
	logic        mgmt_wr, mgmt_rd;
	logic [4:0]  mgmt_reg_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, got, w;
	logic [31:0] r;
	logic        node_repeater_strap = 1'b0, sw_mode_strap = 1'b1, partner_remote_fault = 1'b0;
	logic        isolate = 1'b0, link_is_10base_t = 1'b0, tx_activity = 1'b0, rx_activity = 1'b0;
	logic        pin_cfg_speed_100 = 1'b0, reg_cfg_speed_100 = 1'b0, cfg_speed_100, sqe_test_enable;
	logic        carrier_sense, pair_tx_positive_oe, pair_tx_negative_oe, tx100_power_down;
	int          bad_count = 0, n_compared = 0, seed = 63;
	pxc_ext_ctrl  u_pxc_ext_ctrl (.*);
	pxc_sme_model u_pxc_sme_model (.*);
	initial forever #4 clk_sys = ~clk_sys;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic results;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial begin
		#400000;
		bad_count++;
		results();
	end
	initial begin
		w = 16'h0001;
		for (int i = 0; i < 14; i++) begin
			if (i == 0 || i == 7) begin
				// Start and mid-run resets reload defaults and resample straps
				@(posedge clk_sys);
				reset_n <= 1'b0;
				r = $random(seed);
				{node_repeater_strap, sw_mode_strap} <= r[1:0];
				repeat (20) @(posedge clk_sys);
				reset_n <= 1'b1;
				w = 16'h0001;
			end else begin
				w = $random(seed);
				u_pxc_sme_model.wr(5'h13, w);
				u_pxc_sme_model.wr(5'h12, ~w);
				w = w & 16'h0081;
				if (i == 3) begin
					// A write while the enable is low must leave the register alone
					@(posedge clk_sys);
					clk_en <= 1'b0;
					u_pxc_sme_model.wr(5'h13, ~w);
					clk_en <= 1'b1;
				end
			end
			@(posedge clk_sys);
			r = $random(seed);
			{partner_remote_fault, isolate, link_is_10base_t, tx_activity} <= r[3:0];
			{rx_activity, pin_cfg_speed_100, reg_cfg_speed_100} <= r[6:4];
			repeat (5) @(posedge clk_sys);
			u_pxc_sme_model.rd(got);
			chk(got, {node_repeater_strap, sw_mode_strap, partner_remote_fault, 13'h0000} | w);
			chk({10'h000, cfg_speed_100, sqe_test_enable, carrier_sense, pair_tx_positive_oe,
				pair_tx_negative_oe, tx100_power_down}, {10'h000,
				sw_mode_strap ? reg_cfg_speed_100 : pin_cfg_speed_100, ~node_repeater_strap,
				rx_activity | (tx_activity & ~node_repeater_strap), ~w[7], ~w[7],
				isolate | (w[0] & link_is_10base_t)});
			$display("test %0d done", i);
		end
		results();
	end
endmodule : testbench
`default_nettype wire
